// ---- pkg/pin_mux_regs.svh ----
// Function
// - Port pin zero is a general-purpose I/O or the first active-low external interrupt input, chosen by alternate-function bit 0.
// - The first external interrupt is edge triggered when its trigger-type bit is 1 and level triggered when it is 0.
// - Port pin one is a general-purpose I/O or the second active-low external interrupt input, chosen by alternate-function bit 1.
// - The second external interrupt is edge triggered when its trigger-type bit is 1 and level triggered when it is 0.
// - Port pin two is a general-purpose I/O or the FIFO output-enable input, chosen by the two-bit interface mode field.
// - The FIFO output-enable input is input only, its active level is set by polarity bit 4, and it gates the FIFO data drivers.
// - Port pin three is a general-purpose I/O or the second wake source, chosen by wake control bit 7 together with output-enable bit 3.
// - The second wake source is enabled by wake control bit 1 and its polarity is set by wake control bit 4.
// - While suspended with the second wake source enabled, a transition on its pin restarts the oscillator and interrupts the processor.
// - While the second wake source is enabled and asserted, a request to suspend is refused.
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

`define ADR_PORT_OUT 8'h00
`define ADR_PORT_OE 8'h04
`define ADR_PORT_PINS 8'h08
`define ADR_ALT_CFG 8'h0C
`define ADR_IF_MODE 8'h10
`define ADR_FIFO_POL 8'h14
`define ADR_WAKE_CTL 8'h18
`define ADR_IRQ_TYPE 8'h1C
`define ADR_STATUS 8'h20
`define ADR_SUSPEND 8'h24

`define RST_NIBBLE 4'h0
`define RST_PAIR 2'h0
`define IF_MODE_SLAVE_FIFO 2'h3
`define FIFO_OE_POL_BIT 4
`define WAKE_EN_BIT 1
`define WAKE_POL_BIT 4
`define WAKE_SEL_BIT 7
`define WAKE_PIN 3
`define FIFO_OE_PIN 2
`define ST_WAKE_BIT 2
`define ST_SUSP_BIT 3
`define ST_REFUSED_BIT 4
`define SUSPEND_REQ_BIT 0

`endif

// ---- pkg/pin_mux_pkg.sv ----
package pin_mux_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic select;
        logic second_wake_polarity;
        logic second_wake_enable;
    } wake_ctl_t;

    typedef enum logic {
        PWR_RUN = 1'b0,
        PWR_SUSPENDED = 1'b1
    } power_state_t;

endpackage

// ---- src/pin_cell.sv ----
`timescale 1ns/1ps
module pin_cell (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pad side
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Core side
    input wire logic drive_val,
    input wire logic drive_en,
    input wire logic alt_active,
    output logic level,
    output logic rise,
    output logic fall
);
    logic level_reg;
    logic prev_reg;
    logic oe_reg;
    logic out_reg;

    // Prev only valid after two samples; reset keeps it idle-high
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            level_reg <= 1'b1;
            prev_reg <= 1'b1;
            oe_reg <= 1'b0;
            out_reg <= 1'b0;
        end
        else
        begin
            level_reg <= pin_in;
            prev_reg <= level_reg;
            oe_reg <= drive_en & ~alt_active;
            out_reg <= drive_val;
        end
    end

    assign level = level_reg;
    assign rise = level_reg & ~prev_reg;
    assign fall = ~level_reg & prev_reg;
    assign pin_oe = oe_reg;
    assign pin_out = out_reg;
endmodule

// ---- src/port_a_alternate_function_mux.sv ----
`timescale 1ns/1ps
`include "pin_mux_regs.svh"
module port_a_alternate_function_mux (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Wishbone slave
    input wire pin_mux_pkg::wb_req_t wb_req,
    output pin_mux_pkg::wb_rsp_t wb_rsp,
    // Multiplexed port pins
    input wire logic [3:0] port_pin_i,
    output logic [3:0] port_pin_o,
    output logic [3:0] port_pin_oe,
    // Processor side
    output logic ext_irq_first_req,
    output logic ext_irq_second_req,
    output logic fifo_data_drive_en,
    output logic suspended,
    output logic osc_restart,
    output logic wake_irq
);
    logic [3:0] out_reg;
    logic [3:0] oe_reg;
    logic [1:0] port_alt_function_cfg;
    logic [1:0] interface_mode_cfg;
    logic fifo_pin_polarity_cfg;
    pin_mux_pkg::wake_ctl_t wake_reg;
    logic [1:0] irq_type_reg;
    logic [1:0] irq_flag_reg;
    logic [1:0] irq_flag_next;
    logic wake_flag_reg;
    logic wake_flag_next;
    logic refused_reg;
    logic refused_next;
    pin_mux_pkg::power_state_t state_reg;
    pin_mux_pkg::power_state_t state_next;
    logic osc_reg;
    logic fifo_en_reg;
    logic ack_reg;
    logic [31:0] dat_reg;

    logic [3:0] alt_active;
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic [1:0] irq_req;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;

    // Bus decode
    wire bus_req = wb_req.cyc & wb_req.stb;
    wire wr_commit = bus_req & wb_req.we & ack_reg & wb_req.sel[0];
    wire [7:0] wdat = wb_req.dat[7:0];
    wire wr_out = wr_commit & (wb_req.adr == `ADR_PORT_OUT);
    wire wr_oe = wr_commit & (wb_req.adr == `ADR_PORT_OE);
    wire wr_alt = wr_commit & (wb_req.adr == `ADR_ALT_CFG);
    wire wr_ifm = wr_commit & (wb_req.adr == `ADR_IF_MODE);
    wire wr_pol = wr_commit & (wb_req.adr == `ADR_FIFO_POL);
    wire wr_wake = wr_commit & (wb_req.adr == `ADR_WAKE_CTL);
    wire wr_type = wr_commit & (wb_req.adr == `ADR_IRQ_TYPE);
    wire wr_status = wr_commit & (wb_req.adr == `ADR_STATUS);
    wire wr_susp = wr_commit & (wb_req.adr == `ADR_SUSPEND);

    // Function selection per pin
    assign alt_active[0] = port_alt_function_cfg[0];
    assign alt_active[1] = port_alt_function_cfg[1];
    wire fifo_oe_alt = interface_mode_cfg == `IF_MODE_SLAVE_FIFO;
    assign alt_active[`FIFO_OE_PIN] = fifo_oe_alt;
    // Pin three only becomes a wake input while software leaves it undriven
    wire wake_alt = wake_reg.select & ~oe_reg[`WAKE_PIN];
    assign alt_active[`WAKE_PIN] = wake_alt;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_pin
            pin_cell u_cell (
                .mclk(mclk),
                .rst(rst),
                .pin_in(port_pin_i[g]),
                .pin_out(port_pin_o[g]),
                .pin_oe(port_pin_oe[g]),
                .drive_val(out_reg[g]),
                .drive_en(oe_reg[g]),
                .alt_active(alt_active[g]),
                .level(pin_lvl[g]),
                .rise(pin_rise[g]),
                .fall(pin_fall[g])
            );
        end
        for (g = 0; g < 2; g++)
        begin : g_irq
            // Falling edge latches; the level form follows the pin
            assign irq_set[g] = alt_active[g] & irq_type_reg[g] & pin_fall[g];
            assign irq_clr[g] = wr_status & wdat[g];
            assign irq_flag_next[g] = irq_set[g] | (irq_flag_reg[g] & ~irq_clr[g]);
            assign irq_req[g] = irq_type_reg[g] ? irq_flag_reg[g]
                : (alt_active[g] & ~pin_lvl[g]);
        end
    endgenerate

    assign ext_irq_first_req = irq_req[0];
    assign ext_irq_second_req = irq_req[1];

    // Wake source qualification
    wire wake_live = wake_alt & wake_reg.second_wake_enable;
    wire wake_asserted = wake_live
        & (pin_lvl[`WAKE_PIN] == wake_reg.second_wake_polarity);
    wire wake_edge = wake_live
        & (pin_rise[`WAKE_PIN] | pin_fall[`WAKE_PIN]);
    wire suspend_req = wr_susp & wdat[`SUSPEND_REQ_BIT];
    wire in_suspend = state_reg == pin_mux_pkg::PWR_SUSPENDED;
    wire wake_hit = in_suspend & wake_edge;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pin_mux_pkg::PWR_RUN:
            begin
                if (suspend_req & ~wake_asserted)
                begin
                    state_next = pin_mux_pkg::PWR_SUSPENDED;
                end
            end
            pin_mux_pkg::PWR_SUSPENDED:
            begin
                if (wake_hit)
                begin
                    state_next = pin_mux_pkg::PWR_RUN;
                end
            end
            default:
            begin
                state_next = pin_mux_pkg::PWR_RUN;
            end
        endcase
    end

    // Sticky flags: a set in the clearing cycle wins
    assign wake_flag_next = wake_hit
        | (wake_flag_reg & ~(wr_status & wdat[`ST_WAKE_BIT]));
    assign refused_next = (suspend_req & wake_asserted)
        | (refused_reg & ~(wr_status & wdat[`ST_REFUSED_BIT]));

    // Software-visible registers; reset leaves every pin a plain input
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            out_reg <= `RST_NIBBLE;
            oe_reg <= `RST_NIBBLE;
            port_alt_function_cfg <= `RST_PAIR;
            interface_mode_cfg <= `RST_PAIR;
            fifo_pin_polarity_cfg <= 1'b0;
            wake_reg <= '0;
            irq_type_reg <= `RST_PAIR;
        end
        else
        begin
            if (wr_out)
                out_reg <= wdat[3:0];
            if (wr_oe)
                oe_reg <= wdat[3:0];
            if (wr_alt)
                port_alt_function_cfg <= wdat[1:0];
            if (wr_ifm)
                interface_mode_cfg <= wdat[1:0];
            if (wr_pol)
                fifo_pin_polarity_cfg <= wdat[`FIFO_OE_POL_BIT];
            if (wr_wake)
                wake_reg <= '{select: wdat[`WAKE_SEL_BIT],
                    second_wake_polarity: wdat[`WAKE_POL_BIT],
                    second_wake_enable: wdat[`WAKE_EN_BIT]};
            if (wr_type)
                irq_type_reg <= wdat[1:0];
        end
    end

    // Event and power state
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_flag_reg <= `RST_PAIR;
            wake_flag_reg <= 1'b0;
            refused_reg <= 1'b0;
            state_reg <= pin_mux_pkg::PWR_RUN;
            osc_reg <= 1'b0;
            fifo_en_reg <= 1'b0;
        end
        else
        begin
            irq_flag_reg <= irq_flag_next;
            wake_flag_reg <= wake_flag_next;
            refused_reg <= refused_next;
            state_reg <= state_next;
            osc_reg <= wake_hit;
            fifo_en_reg <= fifo_oe_alt
                & (pin_lvl[`FIFO_OE_PIN] == fifo_pin_polarity_cfg);
        end
    end

    assign suspended = in_suspend;
    assign osc_restart = osc_reg;
    assign wake_irq = wake_flag_reg;
    assign fifo_data_drive_en = fifo_en_reg;

    // Read mux; unmapped addresses read zero
    wire [7:0] status_byte = {3'h0, refused_reg, in_suspend,
        wake_flag_reg, irq_flag_reg};
    wire [7:0] wake_byte = {wake_reg.select, 2'h0,
        wake_reg.second_wake_polarity, 2'h0,
        wake_reg.second_wake_enable, 1'b0};
    wire [7:0] rd_byte =
        (wb_req.adr == `ADR_PORT_OUT) ? {4'h0, out_reg} :
        (wb_req.adr == `ADR_PORT_OE) ? {4'h0, oe_reg} :
        (wb_req.adr == `ADR_PORT_PINS) ? {4'h0, pin_lvl} :
        (wb_req.adr == `ADR_ALT_CFG) ? {6'h00, port_alt_function_cfg} :
        (wb_req.adr == `ADR_IF_MODE) ? {6'h00, interface_mode_cfg} :
        (wb_req.adr == `ADR_FIFO_POL) ?
            {3'h0, fifo_pin_polarity_cfg, 4'h0} :
        (wb_req.adr == `ADR_WAKE_CTL) ? wake_byte :
        (wb_req.adr == `ADR_IRQ_TYPE) ? {6'h00, irq_type_reg} :
        (wb_req.adr == `ADR_STATUS) ? status_byte :
        (wb_req.adr == `ADR_SUSPEND) ? {7'h00, in_suspend} : 8'h00;

    // One wait state: ack in the cycle after the request, then dropped
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req & ~ack_reg)
                dat_reg <= {24'h000000, rd_byte};
        end
    end

    assign wb_rsp.ack = ack_reg;
    assign wb_rsp.dat = dat_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_wake_in_suspend;
        in_suspend ##0 wake_edge;
    endsequence

    sequence s_wake_done;
        osc_restart && !suspended ##0 wake_irq;
    endsequence

    a_pin0_alt_input: assert property (
        port_alt_function_cfg[0] |=> !port_pin_oe[0])
        else $error("pin zero driven while interrupt input");

    a_irq1_trigger: assert property (
        (alt_active[0] && !irq_type_reg[0]
            |-> ext_irq_first_req == !pin_lvl[0])
        and (alt_active[0] && irq_type_reg[0] && pin_fall[0]
            |=> ext_irq_first_req || !irq_type_reg[0]))
        else $error("first interrupt trigger mode wrong");

    a_pin1_alt_input: assert property (
        port_alt_function_cfg[1] |=> !port_pin_oe[1])
        else $error("pin one driven while interrupt input");

    a_irq2_trigger: assert property (
        (alt_active[1] && !irq_type_reg[1]
            |-> ext_irq_second_req == !pin_lvl[1])
        and (alt_active[1] && irq_type_reg[1] && pin_fall[1]
            |=> ext_irq_second_req || !irq_type_reg[1]))
        else $error("second interrupt trigger mode wrong");

    a_pin2_fifo_mode: assert property (
        interface_mode_cfg == `IF_MODE_SLAVE_FIFO |=> !port_pin_oe[2])
        else $error("pin two driven in fifo mode");

    a_fifo_oe_gate: assert property (
        fifo_oe_alt && pin_lvl[2] == fifo_pin_polarity_cfg
            |=> fifo_data_drive_en)
        else $error("fifo drivers not enabled at active level");

    a_fifo_oe_idle: assert property (
        !fifo_oe_alt |=> !fifo_data_drive_en)
        else $error("fifo drivers enabled outside fifo mode");

    a_pin3_wake_mode: assert property (
        wake_reg.select && !oe_reg[3] |=> !port_pin_oe[3])
        else $error("pin three driven while wake source");

    a_wake_exit: assert property (
        s_wake_in_suspend |=> s_wake_done)
        else $error("wake transition did not leave suspend");

    a_suspend_block: assert property (
        suspend_req && !in_suspend && wake_asserted
            |=> !suspended && refused_reg)
        else $error("suspend entered with wake source asserted");

    a_reset_inputs: assert property (
        $fell(rst) |-> port_pin_oe == 4'h0 && !fifo_data_drive_en
            && !suspended && !ext_irq_first_req)
        else $error("pins not plain inputs after reset");

    a_wake_disabled: assert property (
        (in_suspend && !wake_reg.second_wake_enable |=> suspended)
        and (suspend_req && !in_suspend && !wake_reg.second_wake_enable
            |=> suspended))
        else $error("disabled wake source changed suspend");

    a_osc_one_pulse: assert property (
        osc_restart |=> !osc_restart)
        else $error("oscillator restart longer than one cycle");

    a_refuse_holds: assert property (
        !in_suspend && wake_asserted |=> !suspended)
        else $error("suspend entered while wake source asserted");

    a_disabled_quiet: assert property (
        !wake_reg.second_wake_enable |=> !osc_restart && !$rose(wake_irq))
        else $error("disabled wake source raised a wake");

    // Edge flags must survive until software clears them
    a_irq1_flag_sticky: assert property (
        irq_flag_reg[0] && !irq_clr[0] |=> irq_flag_reg[0])
        else $error("first edge interrupt flag lost");

    a_irq2_flag_sticky: assert property (
        irq_flag_reg[1] && !irq_clr[1] |=> irq_flag_reg[1])
        else $error("second edge interrupt flag lost");

    a_reset_outputs: assert property (
        $fell(rst) |-> port_pin_o == 4'h0 && !osc_restart && !wake_irq
            && !ext_irq_second_req)
        else $error("outputs not idle after reset");

endmodule

// ---- dv/board_pins.sv ----
`timescale 1ns/1ps
module board_pins (
    // Device pad side
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe,
    // Board drivers
    input wire logic [3:0] ext_val,
    input wire logic [3:0] ext_en,
    // Resolved pad levels
    output logic [3:0] pad
);
    wire logic [3:0] from_dev = dev_oe & dev_o;
    wire logic [3:0] from_ext = ~dev_oe & ext_en & ext_val;
    // Pull-ups keep idle pins high, as the active-low inputs expect
    wire logic [3:0] pulled = ~dev_oe & ~ext_en;
    assign pad = from_dev | from_ext | pulled;
endmodule

// ---- dv/tb_port_a_alternate_function_mux.sv ----
`timescale 1ns/1ps
`include "pin_mux_regs.svh"
module tb_port_a_alternate_function_mux;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    pin_mux_pkg::wb_req_t wb_req = '0;
    pin_mux_pkg::wb_rsp_t wb_rsp;
    logic [3:0] port_pin_i;
    logic [3:0] port_pin_o;
    logic [3:0] port_pin_oe;
    logic [3:0] ext_val = 4'hF;
    logic [3:0] ext_en = 4'h0;
    logic [1:0] irq;
    logic fifo_en;
    logic susp;
    logic osc;
    logic wirq;
    logic [31:0] rd;
    int err_total = 0;
    int comparisons = 0;

    always #50 mclk = ~mclk;

    port_a_alternate_function_mux dut (
        .mclk(mclk),
        .rst(rst),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp),
        .port_pin_i(port_pin_i),
        .port_pin_o(port_pin_o),
        .port_pin_oe(port_pin_oe),
        .ext_irq_first_req(irq[0]),
        .ext_irq_second_req(irq[1]),
        .fifo_data_drive_en(fifo_en),
        .suspended(susp),
        .osc_restart(osc),
        .wake_irq(wirq)
    );

    board_pins board (
        .dev_o(port_pin_o),
        .dev_oe(port_pin_oe),
        .ext_val(ext_val),
        .ext_en(ext_en),
        .pad(port_pin_i)
    );

    task test_done;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single classic cycle; bounded wait for ack
    task wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr,
                    dat: {24'h0, dat}, sel: 4'h1};
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wb_rsp.ack !== 1'b1 && n < 20);
        if (wb_rsp.ack !== 1'b1)
        begin
            err_total++;
            test_done;
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask

    task wr(input logic [7:0] adr, input logic [7:0] dat);
        wb(1'b1, adr, dat);
    endtask

    task rdchk(input logic [7:0] adr, input logic [7:0] exp, input string nm);
        wb(1'b0, adr, 8'h00);
        chk(nm, rd[7:0], exp);
    endtask

    task pin(input int i, input logic v);
        @(posedge mclk);
        ext_en[i] <= 1'b1;
        ext_val[i] <= v;
        repeat (3) @(posedge mclk);
    endtask

    task s_reset;
        chk("oe", {4'h0, port_pin_oe}, 8'h00);
        chk("outs", {2'h0, irq, fifo_en, susp, osc, wirq}, 8'h00);
        rdchk(`ADR_ALT_CFG, 8'h00, "alt");
        rdchk(`ADR_WAKE_CTL, 8'h00, "wake ctl");
        rdchk(`ADR_IF_MODE, 8'h00, "if mode");
        rdchk(8'h30, 8'h00, "unmapped");
        rdchk(`ADR_PORT_PINS, 8'h0F, "pins");
    endtask

    task s_gpio;
        wr(`ADR_PORT_OE, 8'h0F);
        wr(`ADR_PORT_OUT, 8'h05);
        repeat (2) @(posedge mclk);
        chk("oe", {4'h0, port_pin_oe}, 8'h0F);
        chk("out", {4'h0, port_pin_o}, 8'h05);
        rdchk(`ADR_PORT_PINS, 8'h05, "pins");
        wr(`ADR_ALT_CFG, 8'h03);
        repeat (2) @(posedge mclk);
        chk("oe alt", {4'h0, port_pin_oe}, 8'h0C);
        wr(`ADR_ALT_CFG, 8'h00);
        wr(`ADR_PORT_OE, 8'h00);
    endtask

    task s_irq;
        pin(0, 1'b0);
        chk("irq gpio", {6'h0, irq}, 8'h00);
        pin(0, 1'b1);
        wr(`ADR_ALT_CFG, 8'h03);
        for (int i = 0; i < 2; i++)
        begin
            wr(`ADR_IRQ_TYPE, 8'h00);
            pin(i, 1'b0);
            chk("level low", {7'h0, irq[i]}, 8'h01);
            pin(i, 1'b1);
            chk("level high", {7'h0, irq[i]}, 8'h00);
            wr(`ADR_IRQ_TYPE, 8'h03);
            wr(`ADR_STATUS, 8'h03);
            pin(i, 1'b0);
            pin(i, 1'b1);
            chk("edge held", {7'h0, irq[i]}, 8'h01);
            wr(`ADR_STATUS, 8'h03);
            repeat (2) @(posedge mclk);
            chk("edge clear", {7'h0, irq[i]}, 8'h00);
        end
        wr(`ADR_IRQ_TYPE, 8'h00);
        wr(`ADR_ALT_CFG, 8'h00);
    endtask

    task s_fifo;
        logic f;
        for (int m = 0; m < 4; m++)
        begin
            f = (m == 3);
            wr(`ADR_IF_MODE, m[7:0]);
            wr(`ADR_PORT_OE, 8'h04);
            repeat (2) @(posedge mclk);
            chk("oe two", {7'h0, port_pin_oe[2]}, {7'h0, !f});
            wr(`ADR_PORT_OE, 8'h00);
            wr(`ADR_FIFO_POL, 8'h10);
            pin(2, 1'b1);
            chk("fifo hi act", {7'h0, fifo_en}, {7'h0, f});
            pin(2, 1'b0);
            chk("fifo hi idle", {7'h0, fifo_en}, 8'h00);
            wr(`ADR_FIFO_POL, 8'h00);
            repeat (2) @(posedge mclk);
            chk("fifo lo act", {7'h0, fifo_en}, {7'h0, f});
        end
        pin(2, 1'b1);
        wr(`ADR_IF_MODE, 8'h00);
    endtask

    task wake_edge(input logic v, input logic [7:0] pulses);
        int n;
        n = 0;
        @(posedge mclk);
        ext_val[3] <= v;
        repeat (8)
        begin
            @(posedge mclk);
            if (osc === 1'b1)
                n++;
        end
        chk("osc pulses", n[7:0], pulses);
    endtask

    task s_wake;
        wr(`ADR_WAKE_CTL, 8'h92);
        wr(`ADR_STATUS, 8'h17);
        pin(3, 1'b1);
        wr(`ADR_SUSPEND, 8'h01);
        repeat (2) @(posedge mclk);
        chk("refused", {7'h0, susp}, 8'h00);
        rdchk(`ADR_STATUS, 8'h10, "status");
        wr(`ADR_STATUS, 8'h10);
        pin(3, 1'b0);
        wr(`ADR_SUSPEND, 8'h01);
        repeat (2) @(posedge mclk);
        chk("entered", {7'h0, susp}, 8'h01);
        wake_edge(1'b1, 8'h01);
        chk("woke", {6'h0, susp, wirq}, 8'h01);
        wr(`ADR_STATUS, 8'h04);
        repeat (2) @(posedge mclk);
        chk("wake clr", {7'h0, wirq}, 8'h00);
        // Disabled source: asserted pin must not block or wake
        wr(`ADR_WAKE_CTL, 8'h90);
        wr(`ADR_SUSPEND, 8'h01);
        repeat (2) @(posedge mclk);
        chk("not blocked", {7'h0, susp}, 8'h01);
        wake_edge(1'b0, 8'h00);
        chk("no wake", {6'h0, susp, wirq}, 8'h02);
        wr(`ADR_WAKE_CTL, 8'h82);
        wake_edge(1'b1, 8'h01);
        chk("pol low wake", {6'h0, susp, wirq}, 8'h01);
        // Driven pin three is plain I/O: low level must not refuse suspend
        wr(`ADR_PORT_OE, 8'h08);
        wr(`ADR_SUSPEND, 8'h01);
        repeat (2) @(posedge mclk);
        chk("oe overrides wake", {7'h0, susp}, 8'h01);
        rdchk(`ADR_STATUS, 8'h0C, "status driven");
    endtask

    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        s_reset;
        s_gpio;
        s_irq;
        s_fifo;
        s_wake;
        test_done;
    end
endmodule
